// ### shared/load_compare_consts.vh
// Constants for the signed byte load and signed compare datapath
`ifndef LOAD_COMPARE_CONSTS_VH
`define LOAD_COMPARE_CONSTS_VH

// Operation codes
`define OPC_WIDTH            8
`define OPC_BYTE_LOAD_DISP   8'hC0
`define OPC_BYTE_LOAD_INDEX  8'hC1
`define OPC_CMP_LEQ          8'h0E
`define OPC_CMP_LEQ_IMM      8'h2A
`define OPC_CMP_LESS_DEFAULT 8'h0F

// Operand and modifier layout
`define DATA_WIDTH           32
`define MOD_WIDTH            7
`define BYTE_WIDTH           8
`define DEST_WIDTH           7
`define SLOT_WIDTH           3

// Issue slot ranges
`define LOAD_SLOT_LO         3'h4
`define LOAD_SLOT_HI         3'h5
`define ALU_SLOT_LO          3'h1
`define ALU_SLOT_HI          3'h5

// Compare selector codes inside the compare unit
`define CMP_SEL_WIDTH        2
`define CMP_SEL_LEQ          2'h0
`define CMP_SEL_LEQ_IMM      2'h1
`define CMP_SEL_LESS         2'h2

// Register aperture window defaults
`define APERTURE_BASE_DEFAULT 32'hF0000000
`define APERTURE_SIZE_DEFAULT 32'h00200000

`endif

// ### tb/cache_model.sv
// Data cache model: returns the addressed byte one cycle after a request
`timescale 1ns/1ps
module cache_model (
  input  wire        clock,
  input  wire        clock_enable,
  input  wire        cache_req_valid,
  input  wire [31:0] cache_req_addr,
  output reg  [7:0]  cache_rd_byte
);
  initial cache_rd_byte = 8'h00;
  // Byte is the low address byte; outside its slot the line toggles so
  // a late or early sample never matches by luck
  always @(posedge clock) begin
    if (clock_enable) begin
      if (cache_req_valid) begin
        cache_rd_byte <= cache_req_addr[7:0];
      end else begin
        cache_rd_byte <= ~cache_rd_byte;
      end
    end
  end
endmodule // cache_model

// ### tb/load_compare_exec_assertions.sv
// Port assertions for the load and compare execution stage
`timescale 1ns/1ps
module load_compare_exec_checker #(
  parameter [7:0] OPC_CMP_LESS = 8'h0F
) (
  input wire        clock,
  input wire        rst_n,
  input wire        clock_enable,
  input wire        issue_valid,
  input wire [2:0]  issue_slot,
  input wire [7:0]  opcode,
  input wire [6:0]  modifier,
  input wire [31:0] source_one,
  input wire [31:0] source_two,
  input wire [31:0] guard,
  input wire [6:0]  dest_index,
  input wire [7:0]  cache_rd_byte,
  input wire        cache_req_valid,
  input wire [31:0] cache_req_addr,
  input wire        alu_wb_valid,
  input wire [6:0]  alu_wb_dest,
  input wire [31:0] alu_wb_data,
  input wire        load_wb_valid,
  input wire [31:0] load_wb_data,
  input wire        issue_error
);
  wire        go = issue_valid & guard[0];
  wire        is_ld = opcode == 8'hC0 || opcode == 8'hC1;
  wire        ld_ok = go && is_ld && issue_slot >= 3'h4 &&
                      issue_slot <= 3'h5;
  wire        alu_ok = go && issue_slot != 3'h0 && issue_slot <= 3'h5;
  wire [31:0] imm = {{25{modifier[6]}}, modifier};
  wire [31:0] disp_sum = source_one + imm;
  wire [31:0] idx_sum = source_one + source_two;
  wire [31:0] byte_ext = {{24{cache_rd_byte[7]}}, cache_rd_byte};
  wire        s_leq = $signed(source_one) <= $signed(source_two);
  wire        s_leqi = $signed(source_one) <= $signed(imm);
  wire        s_less = $signed(source_one) < $signed(source_two);
  // Frozen cycles are skipped: every stage moves only on enabled edges
  default clocking cb @(posedge clock iff clock_enable); endclocking
  default disable iff (!rst_n);
  property p_load_req;
    ld_ok && issue_slot <= 3'h5 |=> cache_req_valid;
  endproperty
  a_load_req: assert property (p_load_req)
    else $error("load request missing");
  property p_load_lat;
    cache_req_valid |=> ##1 load_wb_valid;
  endproperty
  a_load_lat: assert property (p_load_lat)
    else $error("load write back late");
  property p_disp_addr;
    ld_ok && opcode == 8'hC0 |=> cache_req_addr == $past(disp_sum);
  endproperty
  a_disp_addr: assert property (p_disp_addr)
    else $error("displacement address wrong");
  property p_idx_addr;
    ld_ok && opcode == 8'hC1 |=> cache_req_addr == $past(idx_sum);
  endproperty
  a_idx_addr: assert property (p_idx_addr)
    else $error("indexed address wrong");
  property p_sext;
    cache_req_valid ##1 1'b1 |=> load_wb_data == $past(byte_ext);
  endproperty
  a_sext: assert property (p_sext)
    else $error("load data not sign extended");
  property p_guard_off;
    issue_valid && !guard[0] |=>
      !cache_req_valid && !alu_wb_valid && !issue_error;
  endproperty
  a_guard_off: assert property (p_guard_off)
    else $error("false guard had an effect");
  property p_leq;
    alu_ok && opcode == 8'h0E |=>
      alu_wb_valid && alu_wb_data == {31'h0, $past(s_leq)};
  endproperty
  a_leq: assert property (p_leq)
    else $error("less or equal result wrong");
  property p_leqi;
    alu_ok && opcode == 8'h2A |=> alu_wb_data == {31'h0, $past(s_leqi)};
  endproperty
  a_leqi: assert property (p_leqi)
    else $error("immediate compare result wrong");
  property p_less;
    alu_ok && opcode == OPC_CMP_LESS |=> alu_wb_valid &&
      alu_wb_data == {31'h0, $past(s_less)} &&
      alu_wb_dest == $past(dest_index);
  endproperty
  a_less: assert property (p_less)
    else $error("less than result wrong");
  property p_bad_slot;
    go && is_ld && issue_slot < 3'h4 |=> issue_error && !cache_req_valid;
  endproperty
  a_bad_slot: assert property (p_bad_slot)
    else $error("load in bad slot not refused");
  c_load: cover property (ld_ok ##3 load_wb_valid);
  c_cmp: cover property (alu_ok ##1 alu_wb_valid);
  c_err: cover property (issue_error);
endmodule // load_compare_exec_checker

bind load_compare_exec load_compare_exec_checker #(
  .OPC_CMP_LESS(OPC_CMP_LESS)) i_chk (.clock(clock), .rst_n(rst_n),
  .clock_enable(clock_enable), .issue_valid(issue_valid),
  .issue_slot(issue_slot), .opcode(opcode), .modifier(modifier),
  .source_one(source_one), .source_two(source_two), .guard(guard),
  .dest_index(dest_index), .cache_rd_byte(cache_rd_byte),
  .cache_req_valid(cache_req_valid), .cache_req_addr(cache_req_addr),
  .alu_wb_valid(alu_wb_valid), .alu_wb_dest(alu_wb_dest),
  .alu_wb_data(alu_wb_data), .load_wb_valid(load_wb_valid),
  .load_wb_data(load_wb_data), .issue_error(issue_error));

// ### tb/test_signed_byte_load_and_compare_ops.sv
// Self-checking bench for the load and compare execution stage
`timescale 1ns/1ps
`include "load_compare_consts.vh"
module test_signed_byte_load_and_compare_ops;
  reg         clock = 1'b0;
  reg         rst_n = 1'b0;
  reg         issue_valid = 1'b0;
  reg  [2:0]  issue_slot = 3'h0;
  reg  [7:0]  opcode = 8'h00;
  reg  [6:0]  modifier = 7'h00;
  reg  [31:0] source_one = 32'h0;
  reg  [31:0] source_two = 32'h0;
  reg  [31:0] guard = 32'h0;
  reg  [6:0]  dest_index = 7'h00;
  reg  [2:0]  cslot = 3'h1;
  wire [7:0]  rd_byte;
  wire        req_v, alu_v, ld_v, ld_undef, err;
  wire [31:0] req_a, alu_d, ld_d;
  wire [6:0]  alu_dst, ld_dst;
  integer     miscompares = 0;
  integer     check_count = 0;
  integer     cycles = 0;
  always #2.5 clock = ~clock;
  load_compare_exec i_dut (.clock(clock), .rst_n(rst_n),
    .clock_enable(1'b1), .issue_valid(issue_valid),
    .issue_slot(issue_slot), .opcode(opcode), .modifier(modifier),
    .source_one(source_one), .source_two(source_two), .guard(guard),
    .dest_index(dest_index), .cache_rd_byte(rd_byte),
    .cache_req_valid(req_v), .cache_req_addr(req_a),
    .alu_wb_valid(alu_v), .alu_wb_dest(alu_dst), .alu_wb_data(alu_d),
    .load_wb_valid(ld_v), .load_wb_dest(ld_dst), .load_wb_data(ld_d),
    .load_wb_undefined(ld_undef), .issue_error(err));
  cache_model i_cache (.clock(clock), .clock_enable(1'b1),
    .cache_req_valid(req_v), .cache_req_addr(req_a),
    .cache_rd_byte(rd_byte));
  ////////////////////////////////////////////////////////////////////////
  task check(input string nm, input [31:0] ev, input [31:0] sv);
    begin
      check_count = check_count + 1;
      if (sv !== ev) begin
        miscompares = miscompares + 1;
        $display("Error %0s expected %h seen %h", nm, ev, sv);
      end
    end
  endtask
  // Drives one op for one cycle; returns just after its answer edge
  task issue(input [2:0] sl, input [7:0] op, input [6:0] md,
             input [31:0] s1, input [31:0] s2, input g);
    begin
      @(posedge clock);
      issue_valid <= 1'b1;
      issue_slot <= sl;
      opcode <= op;
      modifier <= md;
      source_one <= s1;
      source_two <= s2;
      guard <= {31'h7FFFFFFF, g};
      dest_index <= dest_index + 7'h01;
      @(posedge clock);
      issue_valid <= 1'b0;
      #1;
    end
  endtask
  task cmp(input [7:0] op, input [6:0] md, input [31:0] s1,
           input [31:0] s2, input g, input ev);
    begin
      issue(cslot, op, md, s1, s2, g);
      cslot = (cslot == 3'h5) ? 3'h1 : cslot + 3'h1;
      check("cmp valid", {31'h0, g}, {31'h0, alu_v});
      if (g) check("cmp data", {31'h0, ev}, alu_d);
      if (g) check("cmp dest", {25'h0, dest_index}, {25'h0, alu_dst});
    end
  endtask
  task ld(input [7:0] op, input [6:0] md, input [31:0] s1,
          input [31:0] s2, input g, input [31:0] a);
    begin
      issue({2'b10, a[0]}, op, md, s1, s2, g);
      check("req valid", {31'h0, g}, {31'h0, req_v});
      if (g) check("req addr", a, req_a);
      repeat (2) @(posedge clock);
      #1;
      check("load valid", {31'h0, g}, {31'h0, ld_v});
      if (g) check("load data", {{24{a[7]}}, a[7:0]}, ld_d);
      if (g) check("load dest", {25'h0, dest_index}, {25'h0, ld_dst});
      if (g) check("load undef", {31'h0, a - `APERTURE_BASE_DEFAULT <
        `APERTURE_SIZE_DEFAULT}, {31'h0, ld_undef});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_leq;
    begin
      cmp(8'h0E, 7'h00, 32'h3, 32'h4, 1'b1, 1'b1);
      cmp(8'h0E, 7'h00, 32'h1000, 32'h100, 1'b1, 1'b0);
      cmp(8'h0E, 7'h00, 32'h80000000, 32'h4, 1'b1, 1'b1);
      cmp(8'h0E, 7'h00, 32'h80000000, 32'h80000000, 1'b1, 1'b1);
      cmp(8'h0E, 7'h00, 32'h100, 32'h3, 1'b0, 1'b0);
    end
  endtask
  task t_leqi;
    begin
      cmp(8'h2A, 7'h02, 32'h3, 32'h0, 1'b1, 1'b0);
      cmp(8'h2A, 7'h03, 32'h3, 32'h0, 1'b1, 1'b1);
      cmp(8'h2A, 7'h3F, 32'h100, 32'h0, 1'b1, 1'b0);
      cmp(8'h2A, 7'h40, 32'h80000000, 32'h0, 1'b1, 1'b1);
      cmp(8'h2A, 7'h40, 32'hFFFFFFBF, 32'h0, 1'b1, 1'b1);
    end
  endtask
  task t_less;
    begin
      cmp(`OPC_CMP_LESS_DEFAULT, 7'h00, 32'h3, 32'h4, 1'b1, 1'b1);
      cmp(`OPC_CMP_LESS_DEFAULT, 7'h00, 32'h4, 32'h4, 1'b1, 1'b0);
      cmp(`OPC_CMP_LESS_DEFAULT, 7'h00, 32'h80000000, 32'h80000000,
          1'b1, 1'b0);
    end
  endtask
  task t_loads;
    begin
      ld(8'hC0, 7'h02, 32'hD00, 32'h9, 1'b1, 32'hD02);
      ld(8'hC0, 7'h7C, 32'hD88, 32'h0, 1'b1, 32'hD84);
      ld(8'hC0, 7'h3F, 32'hD00, 32'h0, 1'b1, 32'hD3F);
      ld(8'hC0, 7'h40, 32'hD80, 32'h0, 1'b1, 32'hD40);
      ld(8'hC0, 7'h03, 32'hFFFFFFFE, 32'h0, 1'b1, 32'h1);
      ld(8'hC0, 7'h7C, 32'hD04, 32'h0, 1'b0, 32'hD00);
      ld(8'hC1, 7'h7F, 32'hD88, 32'hFFFFFFFC, 1'b1, 32'hD84);
      ld(8'hC1, 7'h00, 32'hD05, 32'hFFFFFFFC, 1'b1, 32'hD01);
      ld(8'hC1, 7'h00, 32'hFFFFFF80, 32'h100, 1'b1, 32'h80);
      ld(8'hC1, 7'h00, 32'hF0000010, 32'h0, 1'b1, 32'hF0000010);
    end
  endtask
  task t_bad_slot;
    begin
      issue(3'h3, 8'hC1, 7'h00, 32'hD00, 32'h0, 1'b1);
      check("slot error", 32'h1, {31'h0, err});
      check("slot req", 32'h0, {31'h0, req_v});
      issue(3'h0, 8'h0E, 7'h00, 32'h1, 32'h2, 1'b1);
      check("alu slot", 32'h0, {31'h0, alu_v});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task conclude;
    begin
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      miscompares = miscompares + 1;
      conclude();
    end
  end
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    t_leq();
    t_leqi();
    t_less();
    t_loads();
    t_bad_slot();
    conclude();
  end
endmodule // test_signed_byte_load_and_compare_ops

// ### verilog/byte_load_unit.v
// Byte load address forming and sign extension of the returned byte
`timescale 1ns/1ps
`include "load_compare_consts.vh"

module byte_load_unit (
  use_index,
  source_one,
  source_two,
  modifier,
  byte_in,
  address,
  word_out
);
  input  wire                    use_index;
  input  wire [`DATA_WIDTH-1:0]  source_one;
  input  wire [`DATA_WIDTH-1:0]  source_two;
  input  wire [`MOD_WIDTH-1:0]   modifier;
  input  wire [`BYTE_WIDTH-1:0]  byte_in;
  output wire [`DATA_WIDTH-1:0]  address;
  output wire [`DATA_WIDTH-1:0]  word_out;

  wire [`DATA_WIDTH-1:0] disp_ext;
  wire [`DATA_WIDTH-1:0] offset;

  // Seven-bit signed displacement, -64 through 63
  assign disp_ext = {{(`DATA_WIDTH-`MOD_WIDTH){modifier[`MOD_WIDTH-1]}},
                     modifier};
  assign offset   = use_index ? source_two : disp_ext;
  // Carry out is dropped on purpose so the sum wraps
  assign address  = source_one + offset;
  // No byte swap: a single byte has no ordering to honour
  assign word_out = {{(`DATA_WIDTH-`BYTE_WIDTH){byte_in[`BYTE_WIDTH-1]}},
                     byte_in};

endmodule // byte_load_unit

// ### verilog/compare_unit.v
// Signed compare logic: less-or-equal, less-or-equal immediate, less-than
`timescale 1ns/1ps
`include "load_compare_consts.vh"

module compare_unit (
  cmp_sel,
  source_one,
  source_two,
  modifier,
  result
);
  input  wire [`CMP_SEL_WIDTH-1:0] cmp_sel;
  input  wire [`DATA_WIDTH-1:0]    source_one;
  input  wire [`DATA_WIDTH-1:0]    source_two;
  input  wire [`MOD_WIDTH-1:0]     modifier;
  output reg                       result;

  wire [`DATA_WIDTH-1:0] imm_ext;

  assign imm_ext = {{(`DATA_WIDTH-`MOD_WIDTH){modifier[`MOD_WIDTH-1]}},
                    modifier};

  function cmp_geq;
    input [`DATA_WIDTH-1:0] x;
    input [`DATA_WIDTH-1:0] y;
    begin
      cmp_geq = ($signed(x) >= $signed(y));
    end
  endfunction

  function cmp_gtr;
    input [`DATA_WIDTH-1:0] x;
    input [`DATA_WIDTH-1:0] y;
    begin
      cmp_gtr = ($signed(x) > $signed(y));
    end
  endfunction

  always @* begin
    case (cmp_sel)
      `CMP_SEL_LEQ:     result = cmp_geq(source_two, source_one);
      `CMP_SEL_LEQ_IMM: result = cmp_geq(imm_ext, source_one);
      `CMP_SEL_LESS:    result = cmp_gtr(source_two, source_one);
      default:          result = 1'b0;
    endcase
  end

endmodule // compare_unit

// ### verilog/load_compare_exec.v
// Execution stage for guarded signed byte loads and signed compares
`timescale 1ns/1ps
`include "load_compare_consts.vh"

// What this block does
// - Displacement load: byte at base plus displacement
// - Displacement is seven-bit signed, -64 to 63
// - Indexed load: byte at base plus index
// - Byte loads ignore the endianness control bit
// - Register aperture byte loads give undefined results
// - True guard: write destination, touch cache status
// - False guard: no write, no side effect
// - Load operation codes are 192 and 193
// - Less-or-equal writes one when source one smaller-or-equal
// - Less-or-equal is greater-or-equal with operands swapped
// - Immediate less-or-equal code 42, register form 14
// - Less-than writes one when strictly below
// - Compare writes destination only when guard true
// - Less-than is greater-than with operands swapped

module load_compare_exec #(
  parameter [`OPC_WIDTH-1:0]  OPC_CMP_LESS  = `OPC_CMP_LESS_DEFAULT,
  parameter [`DATA_WIDTH-1:0] APERTURE_BASE = `APERTURE_BASE_DEFAULT,
  parameter [`DATA_WIDTH-1:0] APERTURE_SIZE = `APERTURE_SIZE_DEFAULT
) (
  input  wire                    clock,
  input  wire                    rst_n,
  input  wire                    clock_enable,
  input  wire                    issue_valid,
  input  wire [`SLOT_WIDTH-1:0]  issue_slot,
  input  wire [`OPC_WIDTH-1:0]   opcode,
  input  wire [`MOD_WIDTH-1:0]   modifier,
  input  wire [`DATA_WIDTH-1:0]  source_one,
  input  wire [`DATA_WIDTH-1:0]  source_two,
  input  wire [`DATA_WIDTH-1:0]  guard,
  input  wire [`DEST_WIDTH-1:0]  dest_index,
  input  wire [`BYTE_WIDTH-1:0]  cache_rd_byte,
  output reg                     cache_req_valid,
  output reg  [`DATA_WIDTH-1:0]  cache_req_addr,
  output reg                     alu_wb_valid,
  output reg  [`DEST_WIDTH-1:0]  alu_wb_dest,
  output reg  [`DATA_WIDTH-1:0]  alu_wb_data,
  output reg                     load_wb_valid,
  output reg  [`DEST_WIDTH-1:0]  load_wb_dest,
  output reg  [`DATA_WIDTH-1:0]  load_wb_data,
  output reg                     load_wb_undefined,
  output reg                     issue_error
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  function slot_in_range;
    input [`SLOT_WIDTH-1:0] slot;
    input [`SLOT_WIDTH-1:0] lo;
    input [`SLOT_WIDTH-1:0] hi;
    begin
      slot_in_range = (slot >= lo) && (slot <= hi);
    end
  endfunction

  wire                      is_load_disp;
  wire                      is_load_index;
  wire                      is_load;
  wire                      is_cmp_leq;
  wire                      is_cmp_leqi;
  wire                      is_cmp_less;
  wire                      is_cmp;
  wire                      load_slot_ok;
  wire                      alu_slot_ok;
  wire                      guard_true;
  wire                      load_go;
  wire                      cmp_go;
  wire                      bad_issue;
  reg  [`CMP_SEL_WIDTH-1:0] cmp_sel;

  assign is_load_disp  = (opcode == `OPC_BYTE_LOAD_DISP);
  assign is_load_index = (opcode == `OPC_BYTE_LOAD_INDEX);
  assign is_load       = is_load_disp | is_load_index;
  assign is_cmp_leq    = (opcode == `OPC_CMP_LEQ);
  assign is_cmp_leqi   = (opcode == `OPC_CMP_LEQ_IMM);
  assign is_cmp_less   = (opcode == OPC_CMP_LESS);
  assign is_cmp        = is_cmp_leq | is_cmp_leqi | is_cmp_less;

  assign load_slot_ok = slot_in_range(issue_slot, `LOAD_SLOT_LO,
                                      `LOAD_SLOT_HI);
  assign alu_slot_ok  = slot_in_range(issue_slot, `ALU_SLOT_LO,
                                      `ALU_SLOT_HI);

  // Only the least significant guard bit matters
  assign guard_true = guard[0];

  // A false guard stops the cache request itself, not only the write back
  assign load_go = issue_valid & is_load & load_slot_ok & guard_true;
  assign cmp_go  = issue_valid & is_cmp & alu_slot_ok & guard_true;

  // Unknown codes and illegal slots are dropped and flagged
  // A false guard suppresses even the error pulse: no side effect at all
  assign bad_issue = issue_valid & guard_true &
                     ((is_load & ~load_slot_ok) |
                      (is_cmp & ~alu_slot_ok) |
                      (~is_load & ~is_cmp));

  always @* begin
    cmp_sel = `CMP_SEL_LEQ;
    if (is_cmp_leqi) begin
      cmp_sel = `CMP_SEL_LEQ_IMM;
    end else if (is_cmp_less) begin
      cmp_sel = `CMP_SEL_LESS;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Datapath units

  wire                   cmp_result;
  wire [`DATA_WIDTH-1:0] load_address;
  wire [`DATA_WIDTH-1:0] load_word;
  wire                   in_aperture;

  compare_unit u_compare (
    .cmp_sel    (cmp_sel),
    .source_one (source_one),
    .source_two (source_two),
    .modifier   (modifier),
    .result     (cmp_result)
  );

  byte_load_unit u_byte_load (
    .use_index  (is_load_index),
    .source_one (source_one),
    .source_two (source_two),
    .modifier   (modifier),
    .byte_in    (cache_rd_byte),
    .address    (load_address),
    .word_out   (load_word)
  );

  // Subtraction form avoids overflow at the top of the address space
  assign in_aperture = ((load_address - APERTURE_BASE) < APERTURE_SIZE);

  ////////////////////////////////////////////////////////////////////////////
  // Compare path: one cycle from issue to write back

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      alu_wb_valid <= 1'b0;
      alu_wb_dest  <= {`DEST_WIDTH{1'b0}};
      alu_wb_data  <= {`DATA_WIDTH{1'b0}};
    end else if (clock_enable) begin
      alu_wb_valid <= cmp_go;
      if (cmp_go) begin
        alu_wb_dest <= dest_index;
        alu_wb_data <= {{(`DATA_WIDTH-1){1'b0}}, cmp_result};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Load path, stage one: request goes to the cache

  reg                   s1_valid_reg;
  reg [`DEST_WIDTH-1:0] s1_dest_reg;
  reg                   s1_aperture_reg;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cache_req_valid <= 1'b0;
      cache_req_addr  <= {`DATA_WIDTH{1'b0}};
      s1_valid_reg    <= 1'b0;
      s1_dest_reg     <= {`DEST_WIDTH{1'b0}};
      s1_aperture_reg <= 1'b0;
    end else if (clock_enable) begin
      cache_req_valid <= load_go;
      s1_valid_reg    <= load_go;
      if (load_go) begin
        cache_req_addr  <= load_address;
        s1_dest_reg     <= dest_index;
        s1_aperture_reg <= in_aperture;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Load path, stage two: cache is producing the byte

  reg                   s2_valid_reg;
  reg [`DEST_WIDTH-1:0] s2_dest_reg;
  reg                   s2_aperture_reg;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s2_valid_reg    <= 1'b0;
      s2_dest_reg     <= {`DEST_WIDTH{1'b0}};
      s2_aperture_reg <= 1'b0;
    end else if (clock_enable) begin
      s2_valid_reg <= s1_valid_reg;
      if (s1_valid_reg) begin
        s2_dest_reg     <= s1_dest_reg;
        s2_aperture_reg <= s1_aperture_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Load path, stage three: byte captured, extended and written back

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      load_wb_valid     <= 1'b0;
      load_wb_dest      <= {`DEST_WIDTH{1'b0}};
      load_wb_data      <= {`DATA_WIDTH{1'b0}};
      load_wb_undefined <= 1'b0;
    end else if (clock_enable) begin
      load_wb_valid <= s2_valid_reg;
      if (s2_valid_reg) begin
        load_wb_dest      <= s2_dest_reg;
        load_wb_data      <= load_word;
        // Result still delivered, but software must not trust it
        load_wb_undefined <= s2_aperture_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Issue error flag

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      issue_error <= 1'b0;
    end else if (clock_enable) begin
      issue_error <= bad_issue;
    end
  end

endmodule // load_compare_exec
